/* File: core/lsd_line_state.sv */
// module: line state array with pipeline updates and diagnostic access
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------------
// Summary of operation
// - fill sets valid; store sets dirty; evict clears
// - used set on fill or free-way hit
// - hit without free way clears all used
// - evict way allocated until fill completes
// - first pass of rmw sets allocated
// - final pass of rmw clears allocated
// - valid/dirty range: code match, bit 22 one
// - used/alloc range: code match, bit 22 zero
// - set from bits 17:8, bank 7:6
// - bits 31:23, 21:18, 5:3 ignored
// - diagnostic reads never check parity
// - valid 23:12, dirty 11:0 read/write
// - valid parity bit 25, dirty parity 24
// - used 23:12, alloc 11:0, alloc parity 24
// - reserved upper bits drop writes
// - used bits carry no parity
// - twelve ways, pseudo-LRU, no flush op
// - direct-mapped mode safe to toggle anytime
// - dm mode picks way from 21:18, c-f alias
module lsd_line_state
    import lsd_pkg::*;
#(
    parameter int unsigned NUM_WAYS = WAYS
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic dm_mode_i,
    input wire lsd_pkg::lsd_upd_t upd_i,
    input wire logic [lsd_pkg::ADDR_BITS-1:0] miss_addr_i,
    output logic [3:0] repl_way_o,
    input wire lsd_pkg::lsd_diag_req_t diag_req_i,
    output logic diag_ready_o,
    output lsd_pkg::lsd_diag_rsp_t diag_rsp_o
);
    import lsd_pkg::*;

    if (NUM_WAYS != WAYS) begin : g_bad_ways
        $error("lsd_line_state supports exactly twelve ways");
    end

    localparam int unsigned NSETS = 1 << IDX_BITS;

    // ------------------------------------------------------------------
    // state arrays
    // ------------------------------------------------------------------
    // used bits have no parity: a flip only alters victim order
    logic [WAYS-1:0] valid_q [NSETS];
    logic [WAYS-1:0] dirty_q [NSETS];
    logic [WAYS-1:0] used_q [NSETS];
    logic [WAYS-1:0] alloc_q [NSETS];
    logic vpar_q [NSETS];
    logic dpar_q [NSETS];
    logic apar_q [NSETS];

    function automatic logic [IDX_BITS-1:0] diag_index(
        input logic [ADDR_BITS-1:0] a);
        // only set and bank bits matter; others alias
        diag_index = {a[SET_MSB:SET_LSB], a[BANK_MSB:BANK_LSB]};
    endfunction

    function automatic logic range_hit(input logic [ADDR_BITS-1:0] a);
        logic [7:0] s;
        s = a[SEL_MSB:SEL_LSB];
        range_hit = (s == SEL_CODE_0) || (s == SEL_CODE_1) ||
                    (s == SEL_CODE_2) || (s == SEL_CODE_3);
    endfunction

    // ------------------------------------------------------------------
    // diagnostic decode
    // ------------------------------------------------------------------
    logic diag_vd, diag_ua, diag_take;
    logic [IDX_BITS-1:0] diag_idx;
    assign diag_vd = range_hit(diag_req_i.addr) &&
                     diag_req_i.addr[VDSEL_BIT];
    assign diag_ua = range_hit(diag_req_i.addr) &&
                     !diag_req_i.addr[VDSEL_BIT];
    assign diag_idx = diag_index(diag_req_i.addr);
    // a diagnostic access waits while the pipeline touches its set
    assign diag_ready_o = !(upd_i.valid && upd_i.op != LSD_OP_NONE &&
                            upd_i.idx == diag_idx);
    assign diag_take = diag_req_i.valid && diag_ready_o;

    // ------------------------------------------------------------------
    // pipeline update decode
    // ------------------------------------------------------------------
    logic [WAYS-1:0] way_oh;
    logic [WAYS-1:0] cur_v, cur_d, cur_u, cur_a;
    logic [WAYS-1:0] nxt_v, nxt_d, nxt_u, nxt_a;
    logic upd_go;
    assign upd_go = upd_i.valid && upd_i.op != LSD_OP_NONE;
    assign way_oh = WAYS'(12'h001 << upd_i.way);
    assign cur_v = valid_q[upd_i.idx];
    assign cur_d = dirty_q[upd_i.idx];
    assign cur_u = used_q[upd_i.idx];
    assign cur_a = alloc_q[upd_i.idx];

    always_comb begin
        nxt_v = cur_v;
        nxt_d = cur_d;
        nxt_u = cur_u;
        nxt_a = cur_a;
        case (upd_i.op)
            LSD_OP_FILL: begin
                nxt_v = cur_v | way_oh;
                nxt_u = cur_u | way_oh;
                nxt_a = cur_a & ~way_oh;
            end
            LSD_OP_HIT, LSD_OP_STORE_HIT: begin
                if (|(~cur_u & ~cur_a & ~way_oh)) begin
                    nxt_u = cur_u | way_oh;
                end else begin
                    nxt_u = '0;
                end
                if (upd_i.op == LSD_OP_STORE_HIT) begin
                    nxt_d = cur_d | way_oh;
                end
            end
            LSD_OP_EVICT: begin
                nxt_v = cur_v & ~way_oh;
                nxt_u = cur_u & ~way_oh;
                nxt_d = cur_d & ~way_oh;
                nxt_a = cur_a | way_oh;
            end
            LSD_OP_DMA64_HIT: begin
                nxt_v = cur_v & ~way_oh;
                nxt_u = cur_u & ~way_oh;
                nxt_d = cur_d & ~way_oh;
            end
            LSD_OP_RMW_FIRST: nxt_a = cur_a | way_oh;
            LSD_OP_RMW_FINAL: nxt_a = cur_a & ~way_oh;
            default: ;
        endcase
    end

    // ------------------------------------------------------------------
    // array write: pipeline update and diagnostic write, never to the same set at once
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NSETS; i++) begin
                valid_q[i] <= STATE_RESET;
                dirty_q[i] <= STATE_RESET;
                used_q[i] <= STATE_RESET;
                alloc_q[i] <= STATE_RESET;
                vpar_q[i] <= 1'b0;
                dpar_q[i] <= 1'b0;
                apar_q[i] <= 1'b0;
            end
        end else begin
            if (upd_go) begin
                valid_q[upd_i.idx] <= nxt_v;
                dirty_q[upd_i.idx] <= nxt_d;
                used_q[upd_i.idx] <= nxt_u;
                alloc_q[upd_i.idx] <= nxt_a;
                vpar_q[upd_i.idx] <= ^nxt_v;
                dpar_q[upd_i.idx] <= ^nxt_d;
                apar_q[upd_i.idx] <= ^nxt_a;
            end
            // upper bits 63:26 (63:25 for used/alloc) are simply not stored
            if (diag_take && diag_req_i.write && diag_vd) begin
                valid_q[diag_idx] <= diag_req_i.wdata[HI_MSB:HI_LSB];
                dirty_q[diag_idx] <= diag_req_i.wdata[LO_MSB:LO_LSB];
                vpar_q[diag_idx] <= diag_req_i.wdata[VPAR_BIT];
                dpar_q[diag_idx] <= diag_req_i.wdata[DPAR_BIT];
            end
            if (diag_take && diag_req_i.write && diag_ua) begin
                used_q[diag_idx] <= diag_req_i.wdata[HI_MSB:HI_LSB];
                alloc_q[diag_idx] <= diag_req_i.wdata[LO_MSB:LO_LSB];
                apar_q[diag_idx] <= diag_req_i.wdata[APAR_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // diagnostic answer: raw bits with the stored parity bits, no parity check
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            diag_rsp_o <= '0;
        end else begin
            diag_rsp_o.valid <= diag_take;
            if (diag_take && diag_vd) begin
                diag_rsp_o.rdata <= {38'h0, vpar_q[diag_idx],
                    dpar_q[diag_idx], valid_q[diag_idx],
                    dirty_q[diag_idx]};
            end else if (diag_take && diag_ua) begin
                diag_rsp_o.rdata <= {39'h0, apar_q[diag_idx],
                    used_q[diag_idx], alloc_q[diag_idx]};
            end else if (diag_take) begin
                diag_rsp_o.rdata <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // victim choice
    // ------------------------------------------------------------------
    // tag match never depends on mode, so toggling is safe
    logic [IDX_BITS-1:0] miss_idx;
    logic [WAYS-1:0] m_u, m_a, m_v;
    logic [3:0] dm_way, lru_way;
    assign miss_idx = diag_index(miss_addr_i);
    assign m_u = used_q[miss_idx];
    assign m_a = alloc_q[miss_idx];
    assign m_v = valid_q[miss_idx];
    assign dm_way = (miss_addr_i[DMWAY_MSB:DMWAY_LSB] > DM_ALIAS_LIMIT) ?
        (miss_addr_i[DMWAY_MSB:DMWAY_LSB] & DM_ALIAS_MASK) :
        miss_addr_i[DMWAY_MSB:DMWAY_LSB];

    // pseudo-LRU: first invalid unallocated way, else first unused unallocated,
    // else first unallocated
    always_comb begin
        logic found;
        found = 1'b0;
        lru_way = 4'h0;
        for (int w = 0; w < WAYS; w++) begin
            if (!found && !m_v[w] && !m_a[w]) begin
                lru_way = 4'(w);
                found = 1'b1;
            end
        end
        for (int w = 0; w < WAYS; w++) begin
            if (!found && !m_u[w] && !m_a[w]) begin
                lru_way = 4'(w);
                found = 1'b1;
            end
        end
        for (int w = 0; w < WAYS; w++) begin
            if (!found && !m_a[w]) begin
                lru_way = 4'(w);
                found = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            repl_way_o <= 4'h0;
        end else begin
            repl_way_o <= dm_mode_i ? dm_way : lru_way;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_fill_sets_valid: assert property (
        upd_go && upd_i.op == LSD_OP_FILL && !diag_take |=>
        valid_q[$past(upd_i.idx)][$past(upd_i.way)])
        else $error("fill did not set valid");
    chk_evict_clears: assert property (
        upd_go && upd_i.op == LSD_OP_EVICT && !diag_take |=>
        !dirty_q[$past(upd_i.idx)][$past(upd_i.way)] &&
        alloc_q[$past(upd_i.idx)][$past(upd_i.way)])
        else $error("evict state wrong");
    chk_used_all_clear: assert property (
        upd_go && upd_i.op == LSD_OP_HIT && !diag_take &&
        !(|(~cur_u & ~cur_a & ~way_oh)) |=> used_q[$past(upd_i.idx)] == '0)
        else $error("used bits not cleared together");
    chk_rmw_alloc_set: assert property (
        upd_go && upd_i.op == LSD_OP_RMW_FIRST && !diag_take |=>
        alloc_q[$past(upd_i.idx)][$past(upd_i.way)])
        else $error("first pass did not allocate");
    chk_rmw_alloc_clr: assert property (
        upd_go && upd_i.op == LSD_OP_RMW_FINAL && !diag_take |=>
        !alloc_q[$past(upd_i.idx)][$past(upd_i.way)])
        else $error("final pass did not release");
    chk_diag_serial: assert property (
        upd_go && upd_i.idx == diag_idx |-> !diag_take)
        else $error("diagnostic overlapped update");
    chk_diag_answer: assert property (
        diag_take |=> diag_rsp_o.valid)
        else $error("diagnostic answer missing");
    chk_vd_read: assert property (
        diag_take && !diag_req_i.write && diag_vd && !upd_go |=>
        diag_rsp_o.rdata[HI_MSB:HI_LSB] == $past(valid_q[diag_idx]))
        else $error("valid bits read wrong");
    chk_dm_way: assert property (
        dm_mode_i |=> repl_way_o <= DM_ALIAS_LIMIT)
        else $error("direct mapped way out of range");
    chk_fill_used: assert property (
        upd_go && upd_i.op == LSD_OP_FILL && !diag_take |=>
        used_q[$past(upd_i.idx)][$past(upd_i.way)] &&
        !alloc_q[$past(upd_i.idx)][$past(upd_i.way)])
        else $error("fill did not set used or free allocation");
    chk_hit_used: assert property (
        upd_go && upd_i.op == LSD_OP_HIT && !diag_take &&
        (|(~cur_u & ~cur_a & ~way_oh)) |=>
        used_q[$past(upd_i.idx)][$past(upd_i.way)])
        else $error("hit did not mark way used");
    chk_store_dirty: assert property (
        upd_go && upd_i.op == LSD_OP_STORE_HIT |=>
        dirty_q[$past(upd_i.idx)][$past(upd_i.way)])
        else $error("store hit did not set dirty");
    chk_evict_invalid: assert property (
        upd_go && upd_i.op == LSD_OP_EVICT |=>
        !valid_q[$past(upd_i.idx)][$past(upd_i.way)] &&
        !used_q[$past(upd_i.idx)][$past(upd_i.way)])
        else $error("evict left the way valid");
    chk_dma_clears: assert property (
        upd_go && upd_i.op == LSD_OP_DMA64_HIT |=>
        !valid_q[$past(upd_i.idx)][$past(upd_i.way)] &&
        !dirty_q[$past(upd_i.idx)][$past(upd_i.way)])
        else $error("dma write hit did not invalidate");
    chk_upd_parity: assert property (
        upd_go |=> vpar_q[$past(upd_i.idx)] == ^valid_q[$past(upd_i.idx)] &&
        apar_q[$past(upd_i.idx)] == ^alloc_q[$past(upd_i.idx)])
        else $error("parity not refreshed on update");
    chk_ua_read: assert property (
        diag_take && !diag_req_i.write && diag_ua && !upd_go |=>
        diag_rsp_o.rdata[HI_MSB:HI_LSB] == $past(used_q[diag_idx]))
        else $error("used bits read wrong");
    chk_vd_write: assert property (
        diag_take && diag_req_i.write && diag_vd |=>
        dirty_q[$past(diag_idx)] == $past(diag_req_i.wdata[LO_MSB:LO_LSB]))
        else $error("dirty bits write lost");
    chk_rsvd_read: assert property (
        diag_rsp_o.valid |-> diag_rsp_o.rdata[63:26] == '0)
        else $error("reserved read bits not zero");
    chk_dm_alias: assert property (
        dm_mode_i && (&miss_addr_i[DMWAY_MSB:DMWAY_MSB-1]) |=>
        repl_way_o == {2'b01, $past(miss_addr_i[DMWAY_LSB+1:DMWAY_LSB])})
        else $error("direct mapped alias wrong");
    chk_dm_direct: assert property (
        dm_mode_i && !miss_addr_i[DMWAY_MSB] |=>
        repl_way_o == $past(miss_addr_i[DMWAY_MSB:DMWAY_LSB]))
        else $error("direct mapped way not taken");

    cov_fill: cover property (upd_go && upd_i.op == LSD_OP_FILL);
    cov_diag_write: cover property (diag_take && diag_req_i.write);
    cov_diag_stall: cover property (diag_req_i.valid && !diag_ready_o);
    cov_used_reset: cover property (upd_go && upd_i.op == LSD_OP_HIT &&
        !(|(~cur_u & ~cur_a & ~way_oh)));
    cov_dm_alias: cover property (dm_mode_i &&
        (&miss_addr_i[DMWAY_MSB:DMWAY_MSB-1]));
endmodule

/* File: core/lsd_pkg.sv */
// package: constants and carrier types for the cache line state block
package lsd_pkg;
    localparam int unsigned WAYS = 12;
    localparam int unsigned SET_BITS = 10;
    localparam int unsigned BANK_BITS = 2;
    localparam int unsigned IDX_BITS = SET_BITS + BANK_BITS;
    localparam int unsigned ADDR_BITS = 40;
    // diagnostic address fields
    localparam int unsigned SEL_MSB = 39;
    localparam int unsigned SEL_LSB = 32;
    localparam int unsigned VDSEL_BIT = 22;
    localparam int unsigned DMWAY_MSB = 21;
    localparam int unsigned DMWAY_LSB = 18;
    localparam int unsigned SET_MSB = 17;
    localparam int unsigned SET_LSB = 8;
    localparam int unsigned BANK_MSB = 7;
    localparam int unsigned BANK_LSB = 6;
    localparam int unsigned LOW_ZERO_MSB = 2;
    // permitted range codes
    localparam logic [7:0] SEL_CODE_0 = 8'ha6;
    localparam logic [7:0] SEL_CODE_1 = 8'ha7;
    localparam logic [7:0] SEL_CODE_2 = 8'hb6;
    localparam logic [7:0] SEL_CODE_3 = 8'hb7;
    // register offsets (address with ignored bits zero)
    localparam logic [39:0] USED_ALLOC_DIAG_OFS = 40'h06_0000_0000;
    localparam logic [39:0] VALID_DIRTY_DIAG_OFS = 40'h06_0040_0000;
    // data word fields
    localparam int unsigned HI_MSB = 23;
    localparam int unsigned HI_LSB = 12;
    localparam int unsigned LO_MSB = 11;
    localparam int unsigned LO_LSB = 0;
    localparam int unsigned VPAR_BIT = 25;
    localparam int unsigned DPAR_BIT = 24;
    localparam int unsigned APAR_BIT = 24;
    localparam logic [WAYS-1:0] STATE_RESET = 12'h000;
    localparam logic [3:0] DM_ALIAS_MASK = 4'h7;
    localparam logic [3:0] DM_ALIAS_LIMIT = 4'hb;

    typedef enum logic [2:0] {
        LSD_OP_NONE = 3'b000,
        LSD_OP_FILL = 3'b001,
        LSD_OP_HIT = 3'b010,
        LSD_OP_STORE_HIT = 3'b011,
        LSD_OP_EVICT = 3'b100,
        LSD_OP_DMA64_HIT = 3'b101,
        LSD_OP_RMW_FIRST = 3'b110,
        LSD_OP_RMW_FINAL = 3'b111
    } lsd_op_t;

    typedef struct packed {
        logic valid;
        lsd_op_t op;
        logic [IDX_BITS-1:0] idx;
        logic [3:0] way;
    } lsd_upd_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_BITS-1:0] addr;
        logic [63:0] wdata;
    } lsd_diag_req_t;

    typedef struct packed {
        logic valid;
        logic [63:0] rdata;
    } lsd_diag_rsp_t;
endpackage

/* File: testbench/lsd_strand_model.sv */
// partner model: a processor strand issuing diagnostic loads and stores
`timescale 1ns/100ps
module lsd_strand_model
    import lsd_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic diag_ready_i,
    output lsd_pkg::lsd_diag_req_t diag_req_o
);
    initial diag_req_o = '0;

    // ------------------------------------------------------------
    // one 64-bit access, held until taken at a rising edge
    // ------------------------------------------------------------
    task automatic access(input logic wr, input logic [39:0] addr,
                          input logic [63:0] wdata, input int gap);
        repeat (gap) @(posedge core_clk_i);
        #1;
        diag_req_o.valid = 1'b1;
        diag_req_o.write = wr;
        diag_req_o.addr = {addr[39:3], 3'h0};
        diag_req_o.wdata = wdata;
        do @(posedge core_clk_i); while (diag_ready_i !== 1'b1);
        #1;
        // scrambled on release so stale values never pass for live ones
        diag_req_o.valid = 1'b0;
        diag_req_o.write = ~wr;
        diag_req_o.addr = ~diag_req_o.addr;
        diag_req_o.wdata = ~wdata;
    endtask
endmodule

/* File: testbench/tb_l2_line_state_diag_access.sv */
// testbench: self-checking bench for the line state block
`timescale 1ns/100ps
module tb_l2_line_state_diag_access;
    import lsd_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic dm_mode_i = 1'b0;
    lsd_upd_t upd_i = '0;
    logic [39:0] miss_addr_i = '0;
    logic [3:0] repl_way_o;
    lsd_diag_req_t diag_req_i;
    logic diag_ready_o;
    lsd_diag_rsp_t diag_rsp_o;
    int unsigned fail_count = 0;
    int unsigned checked = 0;
    logic [63:0] exp_q[$];
    logic [1:0] pend = 2'b00;
    logic [11:0] v, u, a, d, t, x;
    logic [63:0] w;
    logic [7:0] codes[4] = '{SEL_CODE_0, SEL_CODE_1, SEL_CODE_2, SEL_CODE_3};
    lsd_op_t op;
    logic [3:0] wy;

    always #25 core_clk_i = ~core_clk_i;

    lsd_line_state u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .dm_mode_i(dm_mode_i), .upd_i(upd_i), .miss_addr_i(miss_addr_i),
        .repl_way_o(repl_way_o), .diag_req_i(diag_req_i),
        .diag_ready_o(diag_ready_o), .diag_rsp_o(diag_rsp_o));
    lsd_strand_model u_strand (.core_clk_i(core_clk_i),
        .diag_ready_i(diag_ready_o), .diag_req_o(diag_req_i));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    function automatic logic [39:0] mk(input logic [7:0] c, input logic vd,
                                       input logic [11:0] ix);
        return {c, 9'($urandom), vd, 4'($urandom), ix, 3'($urandom), 3'h0};
    endfunction

    function automatic logic [63:0] vdw();
        return {38'h0, ^v, ^d, v, d};
    endfunction

    function automatic logic [63:0] uaw();
        return {39'h0, ^a, u, a};
    endfunction

    function automatic logic [3:0] victim();
        for (int k = 0; k < 3; k++)
            for (int i = 0; i < 12; i++)
                if (!a[i] && (k == 2 || (k == 0 ? !v[i] : !u[i])))
                    return 4'(i);
        return 4'h0;
    endfunction

    task automatic wr(input logic [39:0] ad, input logic [63:0] dt);
        u_strand.access(1'b1, ad, dt, $urandom_range(0, 2));
    endtask

    // the expected word is queued before the load is issued
    task automatic rd(input logic [39:0] ad, input logic [63:0] e);
        exp_q.push_back(e);
        u_strand.access(1'b0, ad, {$urandom, $urandom}, $urandom_range(0, 2));
    endtask

    task automatic apply(input lsd_op_t o, input logic [3:0] n);
        logic [11:0] m;
        m = 12'h1 << n;
        case (o)
            LSD_OP_FILL: {v, u, a} = {v | m, u | m, a & ~m};
            LSD_OP_HIT, LSD_OP_STORE_HIT: begin
                u = |(~u & ~a & ~m) ? u | m : 12'h0;
                d = (o == LSD_OP_STORE_HIT) ? d | m : d;
            end
            LSD_OP_EVICT: {v, u, a, d} = {v & ~m, u & ~m, a | m, d & ~m};
            LSD_OP_DMA64_HIT: {v, u, d} = {v & ~m, u & ~m, d & ~m};
            LSD_OP_RMW_FIRST: a = a | m;
            default: a = a & ~m;
        endcase
    endtask

    task automatic upd(input lsd_op_t o, input logic [3:0] n);
        upd_i = '{valid: 1'b1, op: o, idx: t, way: n};
        #10;
        if (diag_req_i.valid === 1'b1)
            check(64'h0, {63'h0, diag_ready_o});
        @(posedge core_clk_i);
        #1 upd_i.valid = 1'b0;
    endtask

    task automatic results();
        $display("counts: checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // take is seen at the falling edge before the taking edge; the
    // answer stands at the falling edge right after it
    always @(negedge core_clk_i) begin
        if (pend[0]) begin
            check(64'h1, {63'h0, diag_rsp_o.valid});
            check(exp_q.pop_front(), diag_rsp_o.rdata);
        end
        pend = {pend[0], diag_req_i.valid & diag_ready_o & ~diag_req_i.write};
    end

    initial begin
        #1000000;
        fail_count++;
        results();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h823a068f));
        repeat (8) @(posedge core_clk_i);
        #1 rst_n_i = 1'b1;
        t = 12'($urandom);
        rd(mk(codes[0], 1'b1, t), 64'h0);
        rd(mk(codes[2], 1'b0, t), 64'h0);
        $display("test reset_state done");
        for (int i = 0; i < 4; i++) begin
            x = 12'($urandom);
            w = {$urandom, $urandom};
            wr(mk(codes[i], 1'b1, x), w);
            wr(mk(codes[i], 1'b1, x ^ 12'h801), ~w);
            rd(mk(codes[3 - i], 1'b1, x), w & 64'h3ff_ffff);
            wr(mk(codes[i], 1'b0, x), ~w);
            rd(mk(codes[3 - i], 1'b0, x), ~w & 64'h1ff_ffff);
            rd(mk(codes[i], 1'b1, x), w & 64'h3ff_ffff);
            wr(mk(8'ha5, 1'b1, x), ~64'h0);
            rd(mk(codes[i], 1'b1, x), w & 64'h3ff_ffff);
            rd(mk(8'hb5, 1'b0, x), 64'h0);
        end
        $display("test diag_access done");
        t = 12'($urandom);
        miss_addr_i = {22'($urandom), t, 6'h0};
        wr(mk(codes[0], 1'b1, t), 64'h0);
        wr(mk(codes[1], 1'b0, t), 64'h0);
        {v, u, a, d} = '0;
        for (int n = 0; n < 48; n++) begin
            op = lsd_op_t'(3'($urandom_range(1, 7)));
            wy = 4'($urandom_range(0, 11));
            apply(op, wy);
            fork
                upd(op, wy);
                rd(mk(codes[n % 4], 1'b1, t), vdw());
            join
            rd(mk(codes[n % 4], 1'b0, t), uaw());
            check({60'h0, victim()}, {60'h0, repl_way_o});
        end
        $display("test pipeline_updates done");
        for (int k = 0; k < 16; k++) begin
            dm_mode_i = 1'b1;
            miss_addr_i[21:18] = 4'(k);
            @(posedge core_clk_i);
            #1 check({60'h0, 4'(k > 11 ? k - 8 : k)},
                     {60'h0, repl_way_o});
        end
        dm_mode_i = 1'b0;
        rd(mk(codes[1], 1'b1, t), vdw());
        rd(mk(codes[3], 1'b0, t), uaw());
        check({60'h0, victim()}, {60'h0, repl_way_o});
        $display("test direct_mapped done");
        // scrub: fault in, dirty with an unchanged cas, then flush
        wy = 4'($urandom_range(0, 11));
        for (int s = 0; s < 4; s++) begin
            op = (s == 0) ? LSD_OP_FILL : (s == 1) ? LSD_OP_RMW_FIRST :
                 (s == 2) ? LSD_OP_STORE_HIT : LSD_OP_RMW_FINAL;
            apply(op, wy);
            upd(op, wy);
            rd(mk(codes[s], 1'b1, t), vdw());
        end
        dm_mode_i = 1'b1;
        for (int k = 0; k < 12; k++) begin
            miss_addr_i[21:18] = 4'(k);
            @(posedge core_clk_i);
            #1 check({60'h0, 4'(k)}, {60'h0, repl_way_o});
            apply(LSD_OP_EVICT, 4'(k));
            upd(LSD_OP_EVICT, 4'(k));
            rd(mk(codes[k % 4], 1'b0, t), uaw());
            apply(LSD_OP_FILL, 4'(k));
            upd(LSD_OP_FILL, 4'(k));
        end
        dm_mode_i = 1'b0;
        rd(mk(codes[2], 1'b1, t), vdw());
        $display("test scrub_flush done");
        repeat (3) @(posedge core_clk_i);
        results();
    end
endmodule
